// ---- adc_result_serializer_tb.sv ----
// Purpose: self-checking bench of the result serializer
// Assumes: leadframe build; register map as in the package
// Notes: expected streams are built from the word layout alone
`timescale 1ns/10ps
module adc_result_serializer_tb;
  logic sys_clk, rst_b; // clock and reset
  logic [3:0] reg_addr; // register port
  logic [15:0] reg_wdata, reg_rdata, v;
  logic reg_wr, reg_rd;
  logic sck, cs_b, sdi, convert_start; // pins
  logic result_valid, result_is_temp, cfg_read_bit; // result side
  logic [18:0] result_data;
  logic [3:0] result_channel, chan_index;
  logic input_clamp_flag, common_clamp_flag, threshold_alert_flag;
  logic go_config, chan_sel, chan_temp, l0, l0_oe_b, l1, l1_oe_b;
  logic s_cfg, s_sel; // sticky command pulses
  logic [23:0] e, ea, eb; // expected streams
  int num_errors, n_compared, k, s;
  logic [4:0] cmds [6] = '{5'h10, 5'h1F, 5'h0F, 5'h0E, 5'h1F, 5'h0A};
  ////////////////////////////////////////////////////////////////////////
  ars_serializer #(.WAFER_SCALE(1'b0)) dut (.sys_clk(sys_clk),
    .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sck(sck),
    .cs_b(cs_b), .sdi(sdi), .convert_start(convert_start),
    .result_valid(result_valid), .result_data(result_data),
    .result_channel(result_channel), .result_is_temp(result_is_temp),
    .input_clamp_flag(input_clamp_flag),
    .common_clamp_flag(common_clamp_flag),
    .threshold_alert_flag(threshold_alert_flag),
    .cfg_read_bit(cfg_read_bit), .go_config(go_config),
    .chan_sel(chan_sel), .chan_index(chan_index), .chan_temp(chan_temp),
    .lane_zero_o(l0), .lane_zero_oe_b(l0_oe_b), .shared_pin_zero_o(l1),
    .shared_pin_zero_oe_b(l1_oe_b), .general_pin_one_o(),
    .general_pin_one_oe_b(), .general_pin_two_o(), .general_pin_two_oe_b(),
    .general_pin_three_o(), .general_pin_three_oe_b());
  ars_host_model hm (.sck(sck), .cs_b(cs_b), .sdi(sdi), .l0(l0), .l1(l1),
    .oe1_b(l1_oe_b));
  // 20 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // catch one-cycle command pulses
  always @(posedge sys_clk) begin
    if (go_config === 1'b1) s_cfg <= 1'b1;
    if (chan_sel === 1'b1) s_sel <= 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [23:0] x, y);
    n_compared++;
    if (y !== x) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", n, x, y);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // data stand only in the cycle after the read edge
  task automatic rd(input logic [3:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd
  // config: conv, status, merge, lanes, osr, idle, command sequencing
  task automatic setc(input logic cv, st, mg, input logic [1:0] ln, os,
    input logic id, cq);
    wr(ars_pkg::REG_CFG_ADDR, {7'h00, cq, id, os, ln, mg, st, cv});
  endtask : setc
  // convert start, then optionally a result with f = temp,clamp,com,thr
  task automatic res(input logic [18:0] d, input logic [3:0] ch, f,
    input logic ld);
    @(posedge sys_clk);
    convert_start <= 1'b1;
    repeat (4) @(posedge sys_clk);
    convert_start <= 1'b0;
    repeat (6) @(posedge sys_clk);
    {result_is_temp, input_clamp_flag} <= f[3:2];
    {common_clamp_flag, threshold_alert_flag} <= f[1:0];
    result_data <= d;
    result_channel <= ch;
    result_valid <= ld;
    @(posedge sys_clk);
    result_valid <= 1'b0;
  endtask : res
  // stream position p: data msb first, zeros, alert, index, idle
  function automatic logic [23:0] strm(input logic [18:0] d,
    input logic [1:0] o, input logic st, al, input logic [3:0] ix,
    input logic id);
    int p, w;
    w = 16 + o;
    for (p = 0; p < 24; p++)
      strm[p] = p < w ? d[w-1-p] : !st ? id : p < 19 ? 1'b0 :
        p == 19 ? al : ix[23-p];
  endfunction : strm
  task automatic complete_run;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  ////////////////////////////////////////////////////////////////////////
  initial begin
    #2000000 num_errors++;
    complete_run();
  end
  // main sequence
  initial begin
    {rst_b, reg_wr, reg_rd, convert_start, result_valid} = '0;
    {reg_addr, reg_wdata, result_data, result_channel} = '0;
    {result_is_temp, input_clamp_flag, common_clamp_flag} = '0;
    {threshold_alert_flag, cfg_read_bit, s_cfg, s_sel} = '0;
    {num_errors, n_compared} = '0;
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rd(4'h0);
    chk("cfg reset", 24'(ars_pkg::CFG_RST), 24'(v));
    rd(4'h8);
    chk("unmapped read", 24'h0, 24'(v));
    // single lane, every oversampling code, status off and on
    for (k = 0; k < 8; k++) begin
      setc(1'b1, k[2], 1'b0, 2'h0, k[1:0], k[0], 1'b0);
      res(19'h6B3C5 + 19'(k), 4'(k), 4'h4, 1'b1);
      hm.frame(5'h00, 24);
      e = strm(19'h6B3C5 + 19'(k), k[1:0], k[2], 1'b1, 4'(k), k[0]);
      chk("single stream", e, hm.g0);
      chk("lane one off", 24'h0, 24'(hm.e1));
    end
    // alert merge over all flag cases, every input number
    for (k = 0; k < 16; k++) begin
      setc(1'b1, 1'b1, k[0], 2'h0, 2'h0, 1'b0, 1'b0);
      res(19'hA000 + 19'(k), 4'(k), {1'b0, k[1], k[2], k[3]}, 1'b1);
      hm.frame(5'h00, 24);
      e = strm(19'hA000 + 19'(k), 2'h0, 1'b1,
        k[1] | (k[0] ? k[3] : k[2]), 4'(k), 1'b0);
      chk("status word", e, hm.g0);
    end
    // temperature reports fifteen; inputs change after capture
    setc(1'b1, 1'b1, 1'b0, 2'h0, 2'h1, 1'b0, 1'b0);
    res(19'h12345, 4'h3, 4'hC, 1'b1);
    @(posedge sys_clk);
    {result_is_temp, input_clamp_flag} <= 2'b00;
    result_channel <= 4'h6;
    hm.frame(5'h00, 24);
    e = strm(19'h12345, 2'h1, 1'b1, 1'b1, 4'hF, 1'b0);
    chk("temp status", e, hm.g0);
    rd(ars_pkg::REG_STAT_ADDR);
    chk("status reg", 24'h0007E0, 24'(v));
    // two lanes, highest lane first
    setc(1'b1, 1'b1, 1'b0, 2'h1, 2'h3, 1'b1, 1'b0);
    res(19'h4D2B7, 4'hC, 4'h2, 1'b1);
    hm.frame(5'h00, 12);
    e = strm(19'h4D2B7, 2'h3, 1'b1, 1'b1, 4'hC, 1'b1);
    {ea, eb} = '0;
    for (s = 0; s < 12; s++) {eb[s], ea[s]} = {e[2*s], e[2*s+1]};
    chk("dual lane zero", ea, hm.g0);
    chk("dual lane one", eb, hm.g1);
    chk("lane one on", 24'h1, 24'(hm.e1));
    // four-lane and spare codes fall back to one lane here
    for (k = 2; k < 4; k++) begin
      setc(1'b1, 1'b1, 1'b0, 2'(k), 2'h0, 1'b0, 1'b0);
      res(19'h0F0F0, 4'h9, 4'h0, 1'b1);
      hm.frame(5'h00, 24);
      e = strm(19'h0F0F0, 2'h0, 1'b1, 1'b0, 4'h9, 1'b0);
      chk("fallback stream", e, hm.g0);
      chk("fallback lane one", 24'h0, 24'(hm.e1));
    end
    // a new convert start drops the held result
    setc(1'b1, 1'b0, 1'b0, 2'h0, 2'h0, 1'b1, 1'b0);
    res(19'h00000, 4'h1, 4'h0, 1'b1);
    res(19'h00000, 4'h1, 4'h0, 1'b0);
    hm.frame(5'h00, 24);
    chk("dropped result", 24'hFFFFFF, hm.g0);
    // commands: four in command mode, two under the sequencer
    for (k = 0; k < 6; k++) begin
      setc(1'b1, 1'b0, 1'b0, 2'h0, 2'h0, 1'b0, k < 4);
      {s_cfg, s_sel} = 2'b00;
      hm.frame(cmds[k], 8);
      chk("chan select", 24'(k < 3), 24'(s_sel));
      chk("to config", 24'(k == 5), 24'(s_cfg));
      if (k < 2) chk("chan index", 24'(cmds[k][3:0]), 24'(chan_index));
      if (k == 2) chk("chan temp", 24'h1, 24'(chan_temp));
    end
    rd(ars_pkg::REG_CFG_ADDR);
    chk("conv cleared", 24'h0, 24'(v[0]));
    // configuration mode: lane zero only, even with two lanes chosen
    cfg_read_bit <= 1'b1;
    setc(1'b0, 1'b0, 1'b0, 2'h1, 2'h0, 1'b0, 1'b0);
    hm.frame(5'h00, 8);
    chk("config lane zero", 24'hFF, hm.g0);
    chk("config lane one", 24'h0, 24'(hm.e1));
    complete_run();
  end
endmodule : adc_result_serializer_tb

// ---- ars_cmd_decode.sv ----
// Purpose: collect and decode the 5-bit command of a conversion frame
// Assumes: sck_rise and sdi already synchronised to sys_clk
// Notes: only the first five bits of a frame form the command
`timescale 1ns/10ps
module ars_cmd_decode (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic frame_start,
  input wire logic sck_rise,
  input wire logic sdi_bit,
  input wire logic enable,
  input wire logic cmd_seq,
  output logic cmd_done,
  output logic [4:0] cmd_code_r,
  output logic go_config,
  output logic chan_sel,
  output logic [3:0] chan_index,
  output logic chan_temp
);
  logic [2:0] cnt_r; // command bits taken this frame
  logic [4:0] shift_r; // command shift register
  logic take; // sample one command bit
  logic last_bit; // fifth bit arrives now
  logic [4:0] code_nxt; // code after this bit

  assign take = enable && sck_rise && (cnt_r < ars_pkg::CMD_LEN);
  assign last_bit = take && (cnt_r == ars_pkg::CMD_LEN - 3'h1);
  assign code_nxt = {shift_r[3:0], sdi_bit};

  ////////////////////////////////////////////////////////////////////////
  // bit collection, msb first on rising sck
  // R09: five bits per frame
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= 3'h0;
      shift_r <= 5'h00;
      cmd_done <= 1'b0;
      cmd_code_r <= 5'h00;
    end else begin
      cmd_done <= last_bit;
      if (frame_start) begin
        cnt_r <= 3'h0;
      end else if (take) begin
        cnt_r <= cnt_r + 3'h1;
        shift_r <= code_nxt;
      end
      if (last_bit) begin
        cmd_code_r <= code_nxt;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // decode of the finished command (go_config, chan_sel one-cycle pulses; chan_temp, chan_index levels)
  // R11: only the config command acts in sequencer modes
  assign go_config = cmd_done && (cmd_code_r == ars_pkg::CMD_TO_CONFIG);
  // R10: channel commands in command-driven modes
  assign chan_temp = cmd_code_r == ars_pkg::CMD_TEMP;
  assign chan_sel = cmd_done && cmd_seq && (cmd_code_r[4] || chan_temp);
  assign chan_index = cmd_code_r[3:0];
endmodule : ars_cmd_decode

// ---- ars_host_model.sv ----
// Purpose: host serial controller model for the result serializer
// Assumes: serial clock idles low; 400 ns period, free phase to sys_clk
// Notes: samples lanes late in the high phase, well after they settle
`timescale 1ns/10ps
module ars_host_model (
  output logic sck,
  output logic cs_b,
  output logic sdi,
  input wire logic l0,
  input wire logic l1,
  input wire logic oe1_b
);
  logic [23:0] g0; // lane zero bit seen per slot
  logic [23:0] g1; // lane one bit seen per slot
  logic e1; // lane one was driven in the frame
  // idle: no frame, clock stands low
  initial begin
    sck = 1'b0;
    cs_b = 1'b1;
    sdi = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////
  // one framed read of n slots, sending cmd on the data input
  task automatic frame(input logic [4:0] cmd, input int n);
    int s;
    g0 = '0;
    g1 = '0;
    e1 = 1'b0;
    #13 cs_b = 1'b0;
    for (s = 0; s < n; s++) begin
      // command msb first
      // past the command the line toggles, never a stale value
      sdi = (s < 5) ? cmd[4-s] : ~sdi;
      #200 sck = 1'b1;
      #190 g0[s] = l0;
      g1[s] = l1;
      e1 = e1 | ~oe1_b;
      #10 sck = 1'b0;
    end
    #200 cs_b = 1'b1;
    sdi = ~sdi;
    #400;
  endtask : frame
endmodule : ars_host_model

// ---- ars_pkg.sv ----
// Purpose: shared constants and types of the result serializer
// Assumes: register bus of 4-bit address, 16-bit data
// Notes: offsets are byte addresses on the plain register port
package ars_pkg;
  // register map
  localparam logic [3:0] REG_CFG_ADDR = 4'h0;
  localparam logic [3:0] REG_STAT_ADDR = 4'h4;
  localparam logic [15:0] CFG_RST = 16'h0000;
  // configuration field positions
  localparam int CFG_CONV_BIT = 0;
  localparam int CFG_STAT_EN_BIT = 1;
  localparam int CFG_MERGE_BIT = 2;
  localparam int CFG_LANE_LSB = 3;
  localparam int CFG_OSR_LSB = 5;
  localparam int CFG_IDLE_BIT = 7;
  localparam int CFG_CMDSEQ_BIT = 8;
  localparam logic [15:0] CFG_USED_MASK = 16'h01FF;
  // output lane field codes
  localparam logic [1:0] LANE_SEL_ONE = 2'h0;
  localparam logic [1:0] LANE_SEL_TWO = 2'h1;
  localparam logic [1:0] LANE_SEL_FOUR = 2'h2;
  // result word shape
  localparam int DATA_MAX_W = 19;
  localparam logic [4:0] BASE_DATA_W = 5'h10;
  localparam logic [6:0] STAT_WORD_LEN = 7'h18;
  localparam logic [6:0] ALERT_POS = 7'h13;
  localparam logic [3:0] TEMP_INDEX = 4'hF;
  localparam logic [4:0] SLOT_MAX = 5'h1F;
  // commands
  localparam logic [2:0] CMD_LEN = 3'h5;
  localparam logic [4:0] CMD_TO_CONFIG = 5'h0A;
  localparam logic [4:0] CMD_TEMP = 5'h0F;
  // lane modes and frame states
  typedef enum logic [1:0] {LANES_1, LANES_2, LANES_4} ars_lane_t;
  typedef enum logic {FR_IDLE, FR_SHIFT} ars_frame_t;
endpackage : ars_pkg

// ---- ars_serializer.sv ----
// Purpose: conversion-mode serial output of results with status bits
// Assumes: converter logic on sys_clk; sck, cs_b, sdi, convert_start
//          are pins and pass the synchroniser; sck at most sys_clk/8
// Notes: lane pins use active-low output enables
// Functional notes
// R01: five status bits follow each result
// R02: default alert is clamp OR common clamp
// R03: merge select: clamp OR threshold alert
// R04: index carries producing input number
// R05: temperature sensor reports index fifteen
// R06: status off at reset; 24 slots
// R07: status bit4 alert, bits3:0 index
// R08: msb first, width by oversampling, zero fill
// R09: host sends five-bit command per frame
// R10: command modes: 0x0A, 0x0F, 0x10-0x1F act
// R11: sequencer modes: only 0x0A acts
// R12: single lane uses primary pin only
// R13: multi-lane only in conversion mode
// R14: lane field selects one, two, four
// R15: four lanes only in wafer-scale build
// R16: extra lanes mapped to general pins
// R17: empty slots driven at idle level
// R18: lanes change on falling sck
// R19: result held until next convert start
// R20: status captured with its result
`timescale 1ns/10ps
module ars_serializer #(
  parameter bit WAFER_SCALE = 1'b0 // 1: wafer-scale build
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic sck,
  input wire logic cs_b,
  input wire logic sdi,
  input wire logic convert_start,
  input wire logic result_valid,
  input wire logic [18:0] result_data,
  input wire logic [3:0] result_channel,
  input wire logic result_is_temp,
  input wire logic input_clamp_flag,
  input wire logic common_clamp_flag,
  input wire logic threshold_alert_flag,
  input wire logic cfg_read_bit,
  output logic go_config,
  output logic chan_sel,
  output logic [3:0] chan_index,
  output logic chan_temp,
  output logic lane_zero_o,
  output logic lane_zero_oe_b,
  output logic shared_pin_zero_o,
  output logic shared_pin_zero_oe_b,
  output logic general_pin_one_o,
  output logic general_pin_one_oe_b,
  output logic general_pin_two_o,
  output logic general_pin_two_oe_b,
  output logic general_pin_three_o,
  output logic general_pin_three_oe_b
);
  ////////////////////////////////////////////////////////////////////////
  // declarations
  logic [3:0] pins_s; // synchronised sck, cs_b, sdi, convert_start
  logic sck_d_r; // previous synchronised sck
  logic cnv_d_r; // previous synchronised convert_start
  logic cs_d_r; // previous synchronised cs_b
  logic sck_rise; // rising sck seen
  logic sck_fall; // falling sck seen
  logic cnv_rise; // convert start edge
  logic frame_start; // chip select fell
  logic [15:0] cfg_r; // configuration register
  logic [15:0] cfg_nxt; // its next value
  logic [15:0] rdata_nxt; // read data next cycle
  logic [18:0] held_data_r; // result held for reading
  logic [4:0] held_stat_r; // status captured with it
  logic held_valid_r; // held result still current
  logic [18:0] frame_data_r; // frame snapshot of data
  logic [4:0] frame_stat_r; // frame snapshot of status
  logic frame_valid_r; // snapshot holds a result
  logic [4:0] slot_r; // output slot within frame
  ars_pkg::ars_frame_t state_r; // frame state
  logic cmd_done; // command complete pulse
  logic [4:0] cmd_code_r; // last command
  logic conv_mode; // conversion mode bit
  logic status_en; // status append enable
  logic merge_sel; // alert merge select
  logic idle_level; // level of empty slots
  logic [4:0] data_w; // result width in bits
  logic [6:0] word_len; // stream length in bits
  logic alert_now; // alert flag at capture
  logic [3:0] index_now; // index at capture
  ars_pkg::ars_lane_t lane_mode; // effective lane count
  logic [1:0] lane_sh; // log2 of lane count
  logic [3:0] lane_bit; // per-lane stream bit
  logic [3:0] lane_on; // per-lane enable
  logic [3:0] lane_o_r; // registered lane values
  logic [3:0] lane_oe_b_r; // registered lane enables
  logic wr_cfg; // write to configuration
  logic shift_on; // frame active

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers and edge detection
  ars_sync #(.W(4)) u_sync (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .async_in({sck, cs_b, sdi, convert_start}),
    .sync_out(pins_s)
  );

  // edge history, reset to the synchroniser's own reset value (low) so
  // that no false chip select fall follows the release of reset
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sck_d_r <= 1'b0;
      cs_d_r <= 1'b0;
      cnv_d_r <= 1'b0;
    end else begin
      sck_d_r <= pins_s[3];
      cs_d_r <= pins_s[2];
      cnv_d_r <= pins_s[0];
    end
  end

  assign sck_rise = pins_s[3] && !sck_d_r;
  assign sck_fall = !pins_s[3] && sck_d_r;
  assign frame_start = !pins_s[2] && cs_d_r;
  assign cnv_rise = pins_s[0] && !cnv_d_r;
  assign shift_on = (state_r == ars_pkg::FR_SHIFT) && !pins_s[2];

  ////////////////////////////////////////////////////////////////////////
  // register port: decode and configuration fields
  assign wr_cfg = reg_wr && (reg_addr == ars_pkg::REG_CFG_ADDR);
  assign conv_mode = cfg_r[ars_pkg::CFG_CONV_BIT];
  // R06: status append off after reset
  assign status_en = cfg_r[ars_pkg::CFG_STAT_EN_BIT];
  assign merge_sel = cfg_r[ars_pkg::CFG_MERGE_BIT];
  assign idle_level = cfg_r[ars_pkg::CFG_IDLE_BIT];

  // hardware clears conversion mode on the config command
  always_comb begin
    cfg_nxt = cfg_r;
    if (go_config) begin
      cfg_nxt[ars_pkg::CFG_CONV_BIT] = 1'b0;
    end
    if (wr_cfg) begin
      cfg_nxt = reg_wdata & ars_pkg::CFG_USED_MASK;
    end
  end

  // read mux: config, status view, zero elsewhere
  always_comb begin
    rdata_nxt = 16'h0000;
    if (reg_rd && reg_addr == ars_pkg::REG_CFG_ADDR) begin
      rdata_nxt = cfg_r;
    end else if (reg_rd && reg_addr == ars_pkg::REG_STAT_ADDR) begin
      rdata_nxt = {5'h00, held_valid_r, held_stat_r, cmd_code_r};
    end
  end

  // register storage; read data stands one cycle only
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_r <= ars_pkg::CFG_RST;
      reg_rdata <= 16'h0000;
    end else begin
      cfg_r <= cfg_nxt;
      reg_rdata <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // command decoder, active in conversion mode only
  ars_cmd_decode u_cmd (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .frame_start(frame_start),
    .sck_rise(sck_rise),
    .sdi_bit(pins_s[1]),
    .enable(conv_mode && shift_on),
    .cmd_seq(cfg_r[ars_pkg::CFG_CMDSEQ_BIT]),
    .cmd_done(cmd_done),
    .cmd_code_r(cmd_code_r),
    .go_config(go_config),
    .chan_sel(chan_sel),
    .chan_index(chan_index),
    .chan_temp(chan_temp)
  );

  ////////////////////////////////////////////////////////////////////////
  // status formation
  // R02: default alert merges the clamp flags
  // R03: merge select swaps in threshold alert
  assign alert_now = input_clamp_flag |
    (merge_sel ? threshold_alert_flag : common_clamp_flag);
  // R04: index of producing input
  // R05: temperature sensor reports fifteen
  assign index_now = result_is_temp ? ars_pkg::TEMP_INDEX : result_channel;

  // R19: result held until next convert start
  // R20: status latched with the same result
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      held_data_r <= '0;
      held_stat_r <= 5'h00;
      held_valid_r <= 1'b0;
    end else if (result_valid) begin
      held_data_r <= result_data;
      // R07: alert in bit 4, index below
      held_stat_r <= {alert_now, index_now};
      held_valid_r <= 1'b1;
    end else if (cnv_rise) begin
      held_valid_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // frame control: snapshot at chip select, slot per falling sck
  // R18: slots advance on falling sck
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= ars_pkg::FR_IDLE;
      slot_r <= 5'h00;
      frame_data_r <= '0;
      frame_stat_r <= 5'h00;
      frame_valid_r <= 1'b0;
    end else begin
      case (state_r)
        ars_pkg::FR_IDLE: begin
          if (frame_start) begin
            state_r <= ars_pkg::FR_SHIFT;
            slot_r <= 5'h00;
            frame_data_r <= held_data_r;
            frame_stat_r <= held_stat_r;
            frame_valid_r <= held_valid_r;
          end
        end
        ars_pkg::FR_SHIFT: begin
          if (pins_s[2]) begin
            state_r <= ars_pkg::FR_IDLE;
          end else if (sck_fall && slot_r != ars_pkg::SLOT_MAX) begin
            slot_r <= slot_r + 5'h01;
          end
        end
        default: begin
          state_r <= ars_pkg::FR_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // word shape and lane mode
  // R08: width grows with the oversampling code
  assign data_w = ars_pkg::BASE_DATA_W +
    {3'h0, cfg_r[ars_pkg::CFG_OSR_LSB +: 2]};
  // R01: status adds five bits, word of 24
  assign word_len = status_en ? ars_pkg::STAT_WORD_LEN : {2'h0, data_w};

  // R14: lane field decode
  // R15: four lanes only in wafer-scale build
  // R13: lanes beyond one only in conversion mode
  always_comb begin
    lane_mode = ars_pkg::LANES_1;
    if (conv_mode && cfg_r[ars_pkg::CFG_LANE_LSB +: 2] ==
        ars_pkg::LANE_SEL_TWO) begin
      lane_mode = ars_pkg::LANES_2;
    end else if (conv_mode && WAFER_SCALE && cfg_r[ars_pkg::CFG_LANE_LSB +: 2]
        == ars_pkg::LANE_SEL_FOUR) begin
      lane_mode = ars_pkg::LANES_4;
    end
  end
  assign lane_sh = (lane_mode == ars_pkg::LANES_4) ? 2'h2 :
    (lane_mode == ars_pkg::LANES_2) ? 2'h1 : 2'h0;

  // bit of the serial word at a stream position
  function automatic logic stream_bit(input logic [6:0] pos);
    logic [6:0] di;
    di = {2'h0, data_w} - 7'h01 - pos;
    if (!frame_valid_r || pos >= word_len) begin
      // R17: empty slot at idle level
      stream_bit = idle_level;
    end else if (pos < {2'h0, data_w}) begin
      // R08: data msb first
      stream_bit = frame_data_r[di[4:0]];
    end else if (pos < ars_pkg::ALERT_POS) begin
      stream_bit = 1'b0;
    end else if (pos == ars_pkg::ALERT_POS) begin
      stream_bit = frame_stat_r[4];
    end else begin
      di = ars_pkg::STAT_WORD_LEN - 7'h01 - pos;
      stream_bit = frame_stat_r[di[1:0]];
    end
  endfunction : stream_bit

  // per-lane slot interleave, highest lane first
  genvar k;
  generate
    for (k = 0; k < 4; k++) begin : g_lane
      localparam logic [6:0] LK = 7'(k);
      logic [6:0] lane_pos; // stream position on this lane
      assign lane_pos = ({2'h0, slot_r} << lane_sh) +
        ((7'h01 << lane_sh) - 7'h01 - LK);
      assign lane_on[k] = (LK < (7'h01 << lane_sh));
      logic bit_k; // lane bit before the output register
      // always_comb also wakes on the snapshot the function reads
      always_comb begin
        bit_k = stream_bit(lane_pos);
        if (k == 0 && !conv_mode) begin
          bit_k = cfg_read_bit;
        end
      end
      assign lane_bit[k] = bit_k;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // lane output registers; off outside a frame
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      lane_o_r <= 4'h0;
      lane_oe_b_r <= 4'hF;
    end else begin
      lane_o_r <= lane_bit;
      lane_oe_b_r <= shift_on ? ~lane_on : 4'hF;
    end
  end

  // R12: lane zero on the primary pin
  // R16: extra lanes on general pins by build
  assign lane_zero_o = lane_o_r[0];
  assign lane_zero_oe_b = lane_oe_b_r[0];
  assign shared_pin_zero_o = lane_o_r[1];
  assign shared_pin_zero_oe_b = WAFER_SCALE ? 1'b1 : lane_oe_b_r[1];
  assign general_pin_one_o = lane_o_r[1];
  assign general_pin_one_oe_b = WAFER_SCALE ? lane_oe_b_r[1] : 1'b1;
  assign general_pin_two_o = lane_o_r[2];
  assign general_pin_two_oe_b = lane_oe_b_r[2];
  assign general_pin_three_o = lane_o_r[3];
  assign general_pin_three_oe_b = lane_oe_b_r[3];

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  a_alert_default: assert property ( // R02
    result_valid && !merge_sel |=>
      held_stat_r[4] == $past(input_clamp_flag | common_clamp_flag))
    else $error("alert bit not clamp merge");
  a_alert_merged: assert property ( // R03
    result_valid && merge_sel |=>
      held_stat_r[4] == $past(input_clamp_flag | threshold_alert_flag))
    else $error("alert bit not threshold merge");
  a_index_input: assert property ( // R04
    result_valid && !result_is_temp |=>
      held_stat_r[3:0] == $past(result_channel))
    else $error("index differs from input");
  a_index_temp: assert property ( // R05
    result_valid && result_is_temp |=> held_stat_r[3:0] == 4'hF)
    else $error("temperature index not fifteen");
  a_alert_slot: assert property ( // R06
    shift_on && conv_mode && status_en && frame_valid_r &&
      lane_mode == ars_pkg::LANES_1 && slot_r == 5'h13 |=>
      lane_zero_o == frame_stat_r[4])
    else $error("alert not in slot twenty");
  a_msb_first: assert property ( // R08
    shift_on && conv_mode && frame_valid_r &&
      lane_mode == ars_pkg::LANES_1 && slot_r == 5'h00 |=>
      lane_zero_o == frame_data_r[data_w - 5'h01])
    else $error("first slot not msb");
  a_config_lanes: assert property ( // R13
    !conv_mode && $past(!conv_mode) |->
      general_pin_one_oe_b && shared_pin_zero_oe_b &&
      general_pin_two_oe_b && general_pin_three_oe_b)
    else $error("extra lane driven in config mode");
  a_single_lane: assert property ( // R12
    lane_mode == ars_pkg::LANES_1 ##1 lane_mode == ars_pkg::LANES_1 |->
      general_pin_one_oe_b && shared_pin_zero_oe_b)
    else $error("extra lane driven in single mode");
  a_cmd_exit: assert property ( // R11
    go_config && !wr_cfg |=> !conv_mode)
    else $error("config command ignored");
  a_chan_mode: assert property ( // R10
    chan_sel |-> cfg_r[ars_pkg::CFG_CMDSEQ_BIT] && cmd_code_r >= 5'h0F)
    else $error("channel select outside channel commands");

  c_status_frame: cover property (
    shift_on && status_en && slot_r == 5'h17);
  c_two_lane: cover property (shift_on && lane_mode == ars_pkg::LANES_2);
  c_cmd_config: cover property (go_config);
  c_chan_select: cover property (chan_sel && chan_temp);
endmodule : ars_serializer

// ---- ars_sync.sv ----
// Purpose: two-stage synchroniser for pin inputs
// Assumes: inputs are asynchronous to sys_clk
// Notes: the first stage feeds only the second stage
`timescale 1ns/10ps
module ars_sync #(
  parameter int W = 4
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_r; // first stage, read by second only

  ////////////////////////////////////////////////////////////////////////
  // two flip-flops per bit
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= '0;
      sync_out <= '0;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule : ars_sync
